/* File: design/pcrc_regs.vh */
// Register map, field positions, reset values and codes of the checksum unit.
// Included by the checksum unit files; definitions only.
`ifndef PCRC_REGS_VH
`define PCRC_REGS_VH

// Register offsets (byte addresses)
`define PCRC_OFF_DATA        5'h00
`define PCRC_OFF_CTRL        5'h04
`define PCRC_OFF_SEED        5'h08
`define PCRC_OFF_COEFF       5'h0C
`define PCRC_OFF_UNIT        5'h10
`define PCRC_OFF_STAT        5'h14

// Control register fields
`define PCRC_CTRL_RELOAD_BIT 0
`define PCRC_CTRL_WSEL_LSB   6
`define PCRC_CTRL_WSEL_MSB   7

// Unit size register field
`define PCRC_UNIT_LSB        0
`define PCRC_UNIT_MSB        1

// Status register fields
`define PCRC_STAT_BUSY_BIT   0
`define PCRC_STAT_OVR_BIT    1
`define PCRC_STAT_LVL_LSB    2
`define PCRC_STAT_LVL_MSB    3

// Reset values
`define PCRC_RST_ACC         32'h0000_0000
`define PCRC_RST_SEED        32'hFFFF_FFFF
`define PCRC_RST_COEFF       32'h04C1_1DB7
`define PCRC_RST_WSEL        2'h0
`define PCRC_RST_UNIT        2'h2

// Generator width codes
`define PCRC_WSEL_32         2'h0
`define PCRC_WSEL_16         2'h1
`define PCRC_WSEL_8          2'h2
`define PCRC_WSEL_7          2'h3

// Data unit codes
`define PCRC_UNIT_8          2'h0
`define PCRC_UNIT_16         2'h1
`define PCRC_UNIT_32         2'h2

// Bytes folded per clock
`define PCRC_BYTES_PER_CLK   1

`endif

/* File: design/pcrc_fold.v */
// Combinational fold of one byte into the checksum, most significant bit first.
// Assumes the caller registers the result; width code selects the generator size.
`timescale 1ns/1ns
`default_nettype none
`include "pcrc_regs.vh"

module pcrc_fold (
    // Current state and data
    input  wire [31:0] acc_i,
    input  wire [7:0]  byte_i,
    // Generator setup
    input  wire [31:0] coeff_i,
    input  wire [1:0]  wsel_i,
    // Result
    output wire [31:0] acc_o
);

    reg  [31:0] mask;
    reg  [4:0]  top;
    wire [287:0] stage;

    always @* begin
        case (wsel_i)
            `PCRC_WSEL_16: begin
                mask = 32'h0000_FFFF;
                top  = 5'h0F;
            end
            `PCRC_WSEL_8: begin
                mask = 32'h0000_00FF;
                top  = 5'h07;
            end
            `PCRC_WSEL_7: begin
                mask = 32'h0000_007F;
                top  = 5'h06;
            end
            default: begin
                mask = 32'hFFFF_FFFF;
                top  = 5'h1F;
            end
        endcase
    end

    assign stage[31:0] = acc_i & mask;

    // One shift-and-reduce step per data bit
    genvar i;
    generate
        for (i = 0; i < 8; i = i + 1) begin : g_bit
            wire [31:0] cur;
            wire        fb;
            assign cur = stage[32*i +: 32];
            assign fb  = cur[top] ^ byte_i[7-i];
            assign stage[32*(i+1) +: 32] = ({cur[30:0], 1'b0} & mask)
                                         ^ (fb ? (coeff_i & mask) : 32'h0000_0000);
        end
    endgenerate

    assign acc_o = stage[287:256];

endmodule
`default_nettype wire

/* File: design/pcrc_unit.v */
// Programmable checksum unit: register slave, two-entry data buffer, byte fold.
// Assumes a single-clock register master that never holds a strobe longer than one cycle.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
`include "pcrc_regs.vh"

module pcrc_unit (
    // Clock, reset, enable
    input  wire        clock_i,
    input  wire        rst_n_i,
    input  wire        ce_i,
    // Register port
    input  wire [4:0]  addr_i,
    input  wire [31:0] wr_data_i,
    input  wire        wr_i,
    input  wire        rd_i,
    output reg  [31:0] rd_data_o,
    // Buffer state toward the writer
    output wire        data_ready_o,
    output wire        busy_o
);

    // Register file state
    reg  [31:0] acc;
    reg  [31:0] seed;
    reg  [31:0] coeff;
    reg  [1:0]  wsel;
    reg  [1:0]  unit_sel;
    reg         overrun;

    // Two-entry data buffer
    reg  [31:0] buf_word0;
    reg  [31:0] buf_word1;
    reg  [1:0]  buf_last0;
    reg  [1:0]  buf_last1;
    reg         wr_ptr;
    reg         rd_ptr;
    reg  [1:0]  level;

    // Byte walker over the head entry
    reg  [1:0]  byte_cnt;

    // Decode
    wire        sel_data;
    wire        sel_ctrl;
    wire        sel_seed;
    wire        sel_coeff;
    wire        sel_unit;
    wire        sel_stat;

    wire        push_valid;
    wire        push_ready;
    wire        push;
    wire        pop_valid;
    wire        pop_ready;
    wire        pop;
    wire        reload;
    wire        ovr_set;
    wire        ovr_clr;

    wire [31:0] head_word;
    wire [1:0]  head_last;
    wire [1:0]  byte_sel;
    wire [7:0]  head_byte;
    wire [31:0] folded;
    reg  [1:0]  unit_last;
    reg  [31:0] next_rd_data;

    assign sel_data  = (addr_i == `PCRC_OFF_DATA);
    assign sel_ctrl  = (addr_i == `PCRC_OFF_CTRL);
    assign sel_seed  = (addr_i == `PCRC_OFF_SEED);
    assign sel_coeff = (addr_i == `PCRC_OFF_COEFF);
    assign sel_unit  = (addr_i == `PCRC_OFF_UNIT);
    assign sel_stat  = (addr_i == `PCRC_OFF_STAT);

    // Only a write strobe on the data port enters the buffer; reads never do
    assign push_valid   = wr_i & sel_data;
    assign push_ready   = (level != 2'h2);
    assign push         = ce_i & push_valid & push_ready;
    assign data_ready_o = push_ready;
    assign busy_o       = (level != 2'h0);

    // Write of one to the reload bit; a zero there is ignored
    assign reload = ce_i & wr_i & sel_ctrl & wr_data_i[`PCRC_CTRL_RELOAD_BIT];

    // A word written while both entries hold data is dropped and flagged
    assign ovr_set = ce_i & push_valid & ~push_ready;
    assign ovr_clr = ce_i & wr_i & sel_stat & wr_data_i[`PCRC_STAT_OVR_BIT];

    // Number of bytes minus one in a unit of the selected size
    always @* begin
        case (unit_sel)
            `PCRC_UNIT_8:  unit_last = 2'h0;
            `PCRC_UNIT_16: unit_last = 2'h1;
            default:       unit_last = 2'h3;
        endcase
    end

    assign head_word = rd_ptr ? buf_word1 : buf_word0;
    assign head_last = rd_ptr ? buf_last1 : buf_last0;

    // Highest byte of the unit first, walking down to its low byte
    assign byte_sel  = head_last - byte_cnt;
    assign head_byte = head_word[{byte_sel, 3'b000} +: 8];

    assign pop_valid = (level != 2'h0);
    assign pop_ready = (byte_cnt == head_last);
    assign pop       = ce_i & pop_valid & pop_ready & ~reload;

    // One byte per clock through the fold network
    pcrc_fold u_fold (
        .acc_i   (acc),
        .byte_i  (head_byte),
        .coeff_i (coeff),
        .wsel_i  (wsel),
        .acc_o   (folded)
    );

    // Accumulator and byte walker
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            acc      <= `PCRC_RST_ACC;
            byte_cnt <= 2'h0;
        end else if (ce_i) begin
            if (reload) begin
                acc      <= seed;
                byte_cnt <= 2'h0;
            end else if (pop_valid) begin
                acc <= folded;
                if (pop_ready) begin
                    byte_cnt <= 2'h0;
                end else begin
                    byte_cnt <= byte_cnt + 2'h1;
                end
            end
        end
    end

    // Buffer entries, pointers and fill level
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            buf_word0 <= 32'h0000_0000;
            buf_word1 <= 32'h0000_0000;
            buf_last0 <= 2'h0;
            buf_last1 <= 2'h0;
            wr_ptr    <= 1'b0;
            rd_ptr    <= 1'b0;
            level     <= 2'h0;
        end else if (ce_i) begin
            if (reload) begin
                // Reload starts a new computation, so pending words are discarded
                wr_ptr <= 1'b0;
                rd_ptr <= 1'b0;
                level  <= 2'h0;
            end else begin
                if (push) begin
                    if (wr_ptr) begin
                        buf_word1 <= wr_data_i;
                        buf_last1 <= unit_last;
                    end else begin
                        buf_word0 <= wr_data_i;
                        buf_last0 <= unit_last;
                    end
                    wr_ptr <= ~wr_ptr;
                end
                if (pop) begin
                    rd_ptr <= ~rd_ptr;
                end
                if (push && !pop) begin
                    level <= level + 2'h1;
                end else if (pop && !push) begin
                    level <= level - 2'h1;
                end
            end
        end
    end

    // Software registers
    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            seed     <= `PCRC_RST_SEED;
            coeff    <= `PCRC_RST_COEFF;
            wsel     <= `PCRC_RST_WSEL;
            unit_sel <= `PCRC_RST_UNIT;
            overrun  <= 1'b0;
        end else if (ce_i) begin
            if (wr_i) begin
                if (sel_ctrl) begin
                    wsel <= wr_data_i[`PCRC_CTRL_WSEL_MSB:`PCRC_CTRL_WSEL_LSB];
                end else if (sel_seed) begin
                    seed <= wr_data_i;
                end else if (sel_coeff) begin
                    coeff <= wr_data_i;
                end else if (sel_unit) begin
                    unit_sel <= wr_data_i[`PCRC_UNIT_MSB:`PCRC_UNIT_LSB];
                end
            end
            // Set wins over a clear in the same cycle
            if (ovr_set) begin
                overrun <= 1'b1;
            end else if (ovr_clr) begin
                overrun <= 1'b0;
            end
        end
    end

    // Read data for the cycle after the strobe
    always @* begin
        next_rd_data = 32'h0000_0000;
        if (rd_i) begin
            if (sel_data) begin
                next_rd_data = acc;
            end else if (sel_ctrl) begin
                // Reload always reads back as zero
                next_rd_data[`PCRC_CTRL_WSEL_MSB:`PCRC_CTRL_WSEL_LSB] = wsel;
            end else if (sel_seed) begin
                next_rd_data = seed;
            end else if (sel_coeff) begin
                next_rd_data = coeff;
            end else if (sel_unit) begin
                next_rd_data[`PCRC_UNIT_MSB:`PCRC_UNIT_LSB] = unit_sel;
            end else if (sel_stat) begin
                next_rd_data[`PCRC_STAT_BUSY_BIT] = busy_o;
                next_rd_data[`PCRC_STAT_OVR_BIT]  = overrun;
                next_rd_data[`PCRC_STAT_LVL_MSB:`PCRC_STAT_LVL_LSB] = level;
            end
        end
    end

    always @(posedge clock_i) begin
        if (!rst_n_i) begin
            rd_data_o <= 32'h0000_0000;
        end else if (ce_i) begin
            rd_data_o <= next_rd_data;
        end
    end

endmodule
`default_nettype wire

/* File: verification/pcrc_unit_chk.sv */
// Concurrent checks on the checksum unit's register port and buffer flags.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none
module pcrc_unit_chk (
    // Clock, reset, enable
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        ce_i,
    // Register port
    input wire logic [4:0]  addr_i,
    input wire logic [31:0] wr_data_i,
    input wire logic        wr_i,
    input wire logic        rd_i,
    input wire logic [31:0] rd_data_o,
    // Buffer flags
    input wire logic        data_ready_o,
    input wire logic        busy_o
);
    wire rd_go = ce_i && rd_i;
    wire push  = ce_i && wr_i && addr_i == 5'h00;
    wire reload = ce_i && wr_i && addr_i == 5'h04 && wr_data_i[0];
    default clocking @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    idle_read_zero_a: assert property (ce_i && !rd_i |=> rd_data_o == 32'h0)
        else $error("read data not cleared");
    reset_state_a: assert property (disable iff (1'b0)
        !rst_n_i |=> rd_data_o == 32'h0 && data_ready_o && !busy_o)
        else $error("bad reset state");
    unmapped_read_a: assert property (rd_go && addr_i > 5'h14 |=> rd_data_o == 32'h0)
        else $error("unmapped read not zero");
    ctrl_reserved_a: assert property (rd_go && addr_i == 5'h04 |=>
        rd_data_o[31:8] == 24'h0 && rd_data_o[5:0] == 6'h00)
        else $error("control reads set bits");
    push_busy_a: assert property (push && data_ready_o |=> busy_o)
        else $error("word not pending");
    full_busy_a: assert property (!data_ready_o |-> busy_o)
        else $error("full buffer not busy");
    ready_fall_a: assert property ($fell(data_ready_o) |-> $past(push))
        else $error("filled without write");
    busy_rise_a: assert property ($rose(busy_o) |-> $past(push))
        else $error("busy without write");
    reread_same_a: assert property (rd_go && addr_i == 5'h00 && !busy_o
        ##1 rd_go && addr_i == 5'h00 |=> rd_data_o == $past(rd_data_o))
        else $error("read changed checksum");
    reload_flush_a: assert property (reload |=> !busy_o && data_ready_o)
        else $error("reload left words pending");
    enable_freeze_a: assert property (!ce_i |=> $stable(rd_data_o) && $stable(busy_o))
        else $error("state moved while disabled");
    cover property (!data_ready_o);
    cover property (reload && busy_o);
    cover property ($fell(busy_o));
    cover property (rd_go && addr_i > 5'h14);
endmodule
bind pcrc_unit pcrc_unit_chk u_chk (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .data_ready_o(data_ready_o), .busy_o(busy_o)
);
`default_nettype wire

/* File: verification/pcrc_host_model.sv */
// Bus master standing in for the core or DMA writer.
// Assumes the unit samples strobes on each rising edge.
`timescale 1ns/1ns
`default_nettype none
module pcrc_host_model (
    // Clock and read answer
    input  wire logic        clock_i,
    input  wire logic [31:0] rd_data_i,
    // Register port
    output var  logic [4:0]  addr_o,
    output var  logic [31:0] wr_data_o,
    output var  logic        wr_o,
    output var  logic        rd_o
);
    initial {addr_o, wr_data_o, wr_o, rd_o} = 39'h0;
    task put(input logic w, r, input logic [4:0] a, input logic [31:0] d);
        @(posedge clock_i);
        wr_o      <= w;
        rd_o      <= r;
        addr_o    <= a;
        wr_data_o <= d;
    endtask
    // Strobe stays up until the next call, so writes run back to back
    task wr(input logic [4:0] a, input logic [31:0] d);
        put(1'b1, 1'b0, a, d);
    endtask
    task rd(input logic [4:0] a, output logic [31:0] q);
        put(1'b0, 1'b1, a, ~wr_data_o);
        put(1'b0, 1'b0, a, ~wr_data_o);
        #1 q = rd_data_i;
    endtask
endmodule
`default_nettype wire

/* File: verification/pcrc_unit_test.sv */
// Self-checking bench for the checksum unit with a reference fold.
// Assumes the host model drives the bus and the checker is bound.
`timescale 1ns/1ns
`default_nettype none
module pcrc_unit_test;
    logic        clock_i = 1'b0;
    logic        rst_n_i = 1'b0;
    logic        ce_i    = 1'b1;
    wire  [4:0]  addr;
    wire  [31:0] wdata;
    wire  [31:0] rdata;
    wire         wr;
    wire         rd;
    wire         busy;
    wire         ready;
    integer      miscompares = 0;
    integer      comparisons = 0;
    integer      cycles = 0;
    integer      s, u, k;
    logic [31:0] acc;
    logic [31:0] q;
    logic [31:0] poly = 32'h04C1_1DB7;
    logic [31:0] rv [0:5] = '{32'h0, 32'h0, 32'hFFFF_FFFF, 32'h04C1_1DB7, 32'h2, 32'h0};
    pcrc_unit u_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce_i), .addr_i(addr),
        .wr_data_i(wdata), .wr_i(wr), .rd_i(rd), .rd_data_o(rdata),
        .data_ready_o(ready), .busy_o(busy));
    pcrc_host_model u_host (.clock_i(clock_i), .rd_data_i(rdata), .addr_o(addr),
        .wr_data_o(wdata), .wr_o(wr), .rd_o(rd));
    always #25 clock_i = ~clock_i;
    always @(posedge clock_i) begin
        cycles = cycles + 1;
        if (cycles == 5000) begin
            miscompares = miscompares + 1;
            tally_and_finish;
        end
    end
    task tally_and_finish;
        if (miscompares == 0 && comparisons > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task chk(input logic [31:0] e, input logic [31:0] g, input string n);
        comparisons = comparisons + 1;
        if (g !== e) begin
            miscompares = miscompares + 1;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task rchk(input logic [4:0] a, input logic [31:0] e);
        u_host.rd(a, q);
        chk(e, q, $sformatf("register %h", a));
    endtask
    // Width code s picks 32, 16, 8 or 7 bits; bits above the width drop out
    function automatic logic [31:0] fold(input logic [31:0] c, input logic [7:0] b);
        integer i;
        integer w;
        w = (s == 0) ? 32 : (s == 1) ? 16 : (s == 2) ? 8 : 7;
        for (i = 7; i >= 0; i = i - 1)
            c = ((c << 1) ^ ((c[w - 1] ^ b[i]) ? poly : 32'h0)) & (32'hFFFF_FFFF >> (32 - w));
        return c;
    endfunction
    task push(input logic [31:0] d);
        u_host.wr(5'h00, d);
        for (k = (u == 0) ? 0 : (u == 1) ? 1 : 3; k >= 0; k = k - 1)
            acc = fold(acc, d[8 * k +: 8]);
    endtask
    // Counts edges until the buffer has drained, bounded
    task drain;
        u_host.put(1'b0, 1'b0, 5'h00, 32'h0);
        #1;
        for (k = 0; k < 40 && busy === 1'b1; k = k + 1)
            @(posedge clock_i) #1;
    endtask
    initial begin
        repeat (12) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (k = 0; k < 6; k = k + 1)
            rchk(5'(4 * k), rv[k]);
        for (s = 0; s < 4; s = s + 1)
            for (u = 0; u < 3; u = u + 1) begin
                u_host.wr(5'h10, {30'h0, u[1:0]});
                u_host.wr(5'h04, {24'h0, s[1:0], 6'h01});
                acc = 32'hFFFF_FFFF;
                push(32'h9E37_79B9 >> u);
                drain;
                chk((u == 2) ? 4 : u + 1, k, "fold cycles");
                rchk(5'h00, acc);
            end
        s = 0;
        u = 2;
        u_host.wr(5'h10, 32'h2);
        u_host.wr(5'h04, 32'h1);
        acc = 32'hFFFF_FFFF;
        push(32'h0123_4567);
        push(32'h89AB_CDEF);
        u_host.wr(5'h00, 32'hDEAD_BEEF);
        // Both entries hold words here, so the buffer refuses more
        #1 chk(32'h0, {31'h0, ready}, "data ready");
        drain;
        chk(6, k, "fold cycles");
        rchk(5'h00, acc);
        rchk(5'h14, 32'h2);
        u_host.wr(5'h14, 32'h2);
        rchk(5'h14, 32'h0);
        s = 1;
        u = 1;
        poly = 32'h0000_1021;
        u_host.wr(5'h10, 32'h1);
        u_host.wr(5'h08, 32'h0000_1D0F);
        u_host.wr(5'h0C, poly);
        u_host.wr(5'h04, 32'h41);
        rchk(5'h00, 32'h0000_1D0F);
        acc = 32'h0000_1D0F;
        push(32'hFFFF_C0DE);
        drain;
        u_host.wr(5'h04, 32'h40);
        u_host.put(1'b0, 1'b1, 5'h00, 32'h0);
        u_host.rd(5'h00, q);
        chk(acc, q, "data port");
        rchk(5'h04, 32'h40);
        rchk(5'h08, 32'h0000_1D0F);
        rchk(5'h0C, poly);
        u_host.wr(5'h18, 32'hFFFF_FFFF);
        rchk(5'h18, 32'h0);
        @(posedge clock_i) ce_i <= 1'b0;
        u_host.wr(5'h00, 32'h1234_5678);
        u_host.put(1'b0, 1'b0, 5'h00, 32'h0);
        ce_i <= 1'b1;
        rchk(5'h00, acc);
        // Reload while a word is still pending drops it and restarts from the seed
        u_host.wr(5'h00, 32'h5555_AAAA);
        u_host.wr(5'h04, 32'h41);
        rchk(5'h00, 32'h0000_1D0F);
        // Second reset in mid-run restores every register
        @(posedge clock_i) rst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (k = 0; k < 6; k = k + 1)
            rchk(5'(4 * k), rv[k]);
        tally_and_finish;
    end
endmodule
`default_nettype wire
